// ### verilog/flash_qe_pkg.sv
// -----------------------------------------------------------------------------
// Shared constants for the flash query and erase block.
// -----------------------------------------------------------------------------
package flash_qe_pkg;

   // Bus and address widths.
   localparam int ADDR_W  = 21;  // Word address lines A21..A1.
   localparam int DATA_W  = 32;  // Full data bus width.
   localparam int BLK_W   = 5;   // Block number taken from A21..A17.
   localparam int NBLK    = 32;  // Blocks addressable by five lines.
   localparam int BLK_LSB = 16;  // Position of A17 in the word address A21..A1.

   // Command codes.
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;  // Erase setup.
   localparam logic [7:0] CMD_CONFIRM     = 8'hD0;  // Erase confirm / resume.
   localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;  // Back to array reads.
   localparam logic [7:0] CMD_READ_QUERY  = 8'h98;  // Query mode entry.
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;  // Status read mode.
   localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;  // Clear status flags.
   localparam logic [7:0] CMD_SUSPEND     = 8'hB0;  // Program/erase suspend.
   localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;  // Lock setup.
   localparam logic [7:0] CMD_LOCK_SET    = 8'h01;  // Lock confirm.

   // Status register bit positions.
   localparam int READY_BIT      = 7;  // Controller ready.
   localparam int SUSPENDED_BIT  = 6;  // Erase suspended.
   localparam int ERASE_FAIL_BIT = 5;  // Erase failure.
   localparam int PROG_FAIL_BIT  = 4;  // Program failure.
   localparam int SUPPLY_BIT     = 3;  // Program supply invalid.
   localparam int LOCKED_ERR_BIT = 1;  // Erase aimed at a locked block.
   localparam logic [7:0] STATUS_RST = 8'h80;  // Ready, no errors.

   // Query offsets (x32 word addressing) and block status position.
   localparam logic [7:0] BSR_OFFSET = 8'h02;  // Block status at base plus two.
   localparam logic [7:0] EXT_FIRST  = 8'h31;  // First extended-table entry.
   localparam logic [7:0] EXT_LAST   = 8'h3F;  // Last extended-table entry.
   localparam int         EXT_LEN    = 15;     // Entries in the extended table.

   // Erase duration at 40 MHz: nominal 1 ms, shortened by parameter.
   localparam int ERASE_TIME_US = 1000;
   localparam int CLK_MHZ       = 40;
   localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;

   // Extended query table, indexed by offset minus EXT_FIRST, x32 column.
   localparam logic [7:0] EXT_TABLE [EXT_LEN] = '{
      8'h50, 8'h52, 8'h49, 8'h31, 8'h31, 8'h0E, 8'h00, 8'h00,
      8'h00, 8'h01, 8'h00, 8'h33, 8'h50, 8'h00, 8'h00};
   localparam int         SUSP_CAP_IDX   = 9;      // After-suspend entry.
   localparam logic [7:0] SUSP_CAP_X16   = 8'h00;  // Value in 16-bit width.

   // Controller states.
   typedef enum logic [1:0] {ST_IDLE, ST_ERASING, ST_SUSPENDED} ctl_state_t;

   // Read path selection.
   typedef enum logic [1:0] {RD_ARRAY, RD_STATUS, RD_QUERY} read_mode_t;

endpackage : flash_qe_pkg

// ### verilog/lock_bits_if.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// Carries lock-bit requests between controller and lock memory.
// -----------------------------------------------------------------------------
interface lock_bits_if;
   logic [4:0] rdBlock;  // Block whose lock bit is read.
   logic       rdLock;   // Registered lock bit of rdBlock.
   logic       wrEn;     // Set one lock bit.
   logic [4:0] wrBlock;  // Block to lock.
   modport ctl (output rdBlock, output wrEn, output wrBlock, input rdLock);
   modport mem (input rdBlock, input wrEn, input wrBlock, output rdLock);
endinterface : lock_bits_if
`default_nettype wire

// ### verilog/lock_bits_mem.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// Per-block lock memory with registered read data.
// -----------------------------------------------------------------------------
module lock_bits_mem (
   input  wire logic clk,   // System clock.
   input  wire logic srst,  // Synchronous reset; all blocks come up unlocked.
   lock_bits_if.mem  lb     // Lock access port.
);
   logic [flash_qe_pkg::NBLK-1:0] lock_reg;  // One lock flag per block.

   // Lock flags are only ever set here; only reset clears them.
   always_ff @(posedge clk) begin
      if (srst) begin
         lock_reg <= '0;
      end else if (lb.wrEn) begin
         lock_reg[lb.wrBlock] <= 1'b1;
      end
   end

   // Read data come from a register, one cycle after the block number.
   always_ff @(posedge clk) begin
      if (srst) begin
         lb.rdLock <= 1'b0;
      end else begin
         lb.rdLock <= lock_reg[lb.rdBlock];
      end
   end
endmodule : lock_bits_mem
`default_nettype wire

// ### verilog/flash_query_and_erase_flow.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Base-plus-two query read returns lock bit0 in x32; in x16 it is at base plus four and five; the code answers in x16 at base plus eight to eleven.
// - Block base taken from A21..A17 only.
// - Status byte bits 7..2 and 1 read zero.
// - Extended table begins with P, R, I.
// - Feature byte reads 0Eh, upper bits zero.
// - After-suspend byte 01h x32, 00h x16.
// - Block status mask entry reads 00h.
// - Voltage entries 33h, 50h; reserved 00h.
// - Voltage bytes: hex volts, BCD tenths.
// - Accepted erase switches reads to status.
// - Ready bit set when controller done.
// - Bad program supply sets supply bit.
// - Bad sequence sets bits 4 and 5.
// - Erase failure sets bit 5 alone.
// - Locked block erase sets bit 1, no change.
// - Query data on low eight lines only.
module flash_query_and_erase_flow #(
   parameter int ERASE_CYCLES = flash_qe_pkg::ERASE_CYCLES  // Shorten in simulation.
) (
   input  wire logic        clk,          // 40 MHz system clock.
   input  wire logic        srst,         // Synchronous reset, active high.
   input  wire logic [20:0] addrLines,    // Word address A21..A1 (pin).
   input  wire logic [31:0] dataIn,       // Data lines, input half.
   output logic      [31:0] dataOut,      // Data lines, output half.
   output logic             dataOe_n,     // Low while the block drives data.
   input  wire logic        chipEn_n,     // Chip enable (pin).
   input  wire logic        outEn_n,      // Output enable (pin).
   input  wire logic        writeEn_n,    // Write enable (pin).
   input  wire logic        wordMode,     // High for x32, low for x16 (pin).
   input  wire logic        supplyOk,     // Program supply valid (pin).
   input  wire logic        eraseFault,   // Cell array reports erase failure.
   output logic             readyBusy,    // High when the controller is ready.
   output logic             eraseStart,   // One-cycle pulse: begin array erase.
   output logic      [4:0]  eraseBlock    // Block being erased.
);
   // -------------------------------------------------------------------------
   // Pin synchronisers.
   // -------------------------------------------------------------------------
   logic [20:0] addrS1_reg, addrS2_reg;    // Address synchroniser.
   logic [31:0] dinS1_reg,  dinS2_reg;     // Data synchroniser.
   logic [5:0]  ctlS1_reg,  ctlS2_reg;     // Control pin synchroniser.
   logic        weLast_reg;                // Previous write enable level.

   // Two flops on every pin before any logic looks at it.
   always_ff @(posedge clk) begin
      addrS1_reg <= addrLines;
      addrS2_reg <= addrS1_reg;
      dinS1_reg  <= dataIn;
      dinS2_reg  <= dinS1_reg;
      ctlS1_reg  <= {eraseFault, supplyOk, wordMode, writeEn_n, outEn_n, chipEn_n};
      ctlS2_reg  <= ctlS1_reg;
   end

   wire       ceN     = ctlS2_reg[0];  // Synchronised chip enable.
   wire       oeN     = ctlS2_reg[1];  // Synchronised output enable.
   wire       weN     = ctlS2_reg[2];  // Synchronised write enable.
   wire       x32     = ctlS2_reg[3];  // Bus width select.
   wire       vppOk   = ctlS2_reg[4];  // Program supply valid.
   wire       arrFail = ctlS2_reg[5];  // Array erase failure.
   wire [7:0] cmd     = dinS2_reg[7:0];

   // A command is taken on the rising edge of write enable with chip enabled.
   wire       wrStrobe = ~ceN & weN & ~weLast_reg;

   always_ff @(posedge clk) begin
      if (srst) begin
         weLast_reg <= 1'b1;
      end else begin
         weLast_reg <= weN;
      end
   end

   // -------------------------------------------------------------------------
   // Address decode.
   // -------------------------------------------------------------------------
   // The block number ignores every line below A17.
   wire [4:0] addrBlock = addrS2_reg[flash_qe_pkg::BLK_LSB +: flash_qe_pkg::BLK_W];
   // In x16 the table is doubled, so the low word bit is dropped; in x32 A1
   // is a don't-care and A2 is the lowest significant line.
   wire [7:0] qOffX16 = {1'b0, addrS2_reg[7:1]};
   wire [7:0] qSel = x32 ? addrS2_reg[8:1] : qOffX16;
   // Offset within the block; in x32 in the same units as the table offsets, in x16 with A2 also dropped.
   wire [15:0] inBlk = x32 ? {1'b0, addrS2_reg[15:1]} : {2'b00, addrS2_reg[15:2]};
   wire        isBsr = (inBlk == {8'h00, flash_qe_pkg::BSR_OFFSET});
   wire        isExt = (qSel >= flash_qe_pkg::EXT_FIRST) && (qSel <= flash_qe_pkg::EXT_LAST);
   wire [7:0]  extIdx = qSel - flash_qe_pkg::EXT_FIRST;

   // -------------------------------------------------------------------------
   // Command state and status register.
   // -------------------------------------------------------------------------
   flash_qe_pkg::ctl_state_t state_reg, state_next;
   flash_qe_pkg::read_mode_t rdMode_reg, rdMode_next;
   logic        setupPend_reg;   // Erase setup seen, waiting for confirm.
   logic        lockPend_reg;    // Lock setup seen.
   logic [7:0]  status_reg;      // Status register (ready, errors).
   logic [31:0] eraseCnt_reg;    // Erase time counter.
   logic        pendLock_reg;    // Lock check in flight for a confirm.
   logic [4:0]  tgtBlock_reg;    // Target of the confirm.

   lock_bits_if lb ();
   lock_bits_mem u_locks (.clk(clk), .srst(srst), .lb(lb));
   assign lb.rdBlock = pendLock_reg ? tgtBlock_reg : addrBlock;
   assign lb.wrEn    = wrStrobe & lockPend_reg & (cmd == flash_qe_pkg::CMD_LOCK_SET);
   assign lb.wrBlock = addrBlock;

   wire isConfirm = wrStrobe & setupPend_reg & (cmd == flash_qe_pkg::CMD_CONFIRM);
   wire badSeq    = wrStrobe & setupPend_reg & (cmd != flash_qe_pkg::CMD_CONFIRM);
   wire eraseDone = (state_reg == flash_qe_pkg::ST_ERASING) && (eraseCnt_reg == 32'h00000001);

   // Controller sequencing.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         flash_qe_pkg::ST_IDLE: begin
            // Lock result is back one cycle after the confirm was seen.
            if (pendLock_reg && vppOk && !lb.rdLock) begin
               state_next = flash_qe_pkg::ST_ERASING;
            end
         end
         flash_qe_pkg::ST_ERASING: begin
            if (wrStrobe && cmd == flash_qe_pkg::CMD_SUSPEND) begin
               state_next = flash_qe_pkg::ST_SUSPENDED;
            end else if (eraseDone) begin
               state_next = flash_qe_pkg::ST_IDLE;
            end
         end
         flash_qe_pkg::ST_SUSPENDED: begin
            if (wrStrobe && cmd == flash_qe_pkg::CMD_CONFIRM) begin
               state_next = flash_qe_pkg::ST_ERASING;
            end
         end
         default: state_next = flash_qe_pkg::ST_IDLE;
      endcase
   end

   // Read mode: erase commands leave the device reading status.
   always_comb begin
      rdMode_next = rdMode_reg;
      if (wrStrobe) begin
         case (cmd)
            flash_qe_pkg::CMD_READ_ARRAY:  rdMode_next = flash_qe_pkg::RD_ARRAY;
            flash_qe_pkg::CMD_READ_QUERY:  rdMode_next = flash_qe_pkg::RD_QUERY;
            flash_qe_pkg::CMD_READ_STATUS,
            flash_qe_pkg::CMD_ERASE_SETUP,
            flash_qe_pkg::CMD_CONFIRM,
            flash_qe_pkg::CMD_SUSPEND:     rdMode_next = flash_qe_pkg::RD_STATUS;
            default:                       rdMode_next = rdMode_reg;
         endcase
      end
   end

   // Register update; kept short, the decisions are made above.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg     <= flash_qe_pkg::ST_IDLE;
         rdMode_reg    <= flash_qe_pkg::RD_ARRAY;
         setupPend_reg <= 1'b0;
         lockPend_reg  <= 1'b0;
         pendLock_reg  <= 1'b0;
         tgtBlock_reg  <= '0;
      end else begin
         state_reg     <= state_next;
         rdMode_reg    <= rdMode_next;
         pendLock_reg  <= isConfirm;
         if (isConfirm) begin
            tgtBlock_reg <= addrBlock;
         end
         if (wrStrobe) begin
            setupPend_reg <= (cmd == flash_qe_pkg::CMD_ERASE_SETUP);
            lockPend_reg  <= (cmd == flash_qe_pkg::CMD_LOCK_SETUP);
         end
      end
   end

   // Erase timer: loaded on start, frozen while suspended.
   always_ff @(posedge clk) begin
      if (srst) begin
         eraseCnt_reg <= '0;
      end else if (state_reg == flash_qe_pkg::ST_IDLE && state_next == flash_qe_pkg::ST_ERASING) begin
         eraseCnt_reg <= 32'(ERASE_CYCLES);
      end else if (state_reg == flash_qe_pkg::ST_ERASING && eraseCnt_reg != '0) begin
         eraseCnt_reg <= eraseCnt_reg - 32'h00000001;
      end
   end

   // Status register. Error bits are sticky: only clear-status removes them,
   // and a new error in the same cycle wins over the clear.
   wire clrStat = wrStrobe & (cmd == flash_qe_pkg::CMD_CLEAR_STAT);
   wire lockErr = pendLock_reg & lb.rdLock;
   wire vppErr  = pendLock_reg & ~vppOk;
   wire failErr = eraseDone & arrFail;

   always_ff @(posedge clk) begin
      if (srst) begin
         status_reg <= flash_qe_pkg::STATUS_RST;
      end else begin
         if (clrStat) begin
            status_reg[5:1] <= '0;
         end
         // Ready while no erase runs or the erase is suspended.
         status_reg[flash_qe_pkg::READY_BIT]     <= (state_next != flash_qe_pkg::ST_ERASING);
         status_reg[flash_qe_pkg::SUSPENDED_BIT] <= (state_next == flash_qe_pkg::ST_SUSPENDED);
         if (badSeq) begin
            status_reg[flash_qe_pkg::PROG_FAIL_BIT]  <= 1'b1;
            status_reg[flash_qe_pkg::ERASE_FAIL_BIT] <= 1'b1;
         end
         if (failErr) begin
            status_reg[flash_qe_pkg::ERASE_FAIL_BIT] <= 1'b1;
         end
         if (vppErr) begin
            status_reg[flash_qe_pkg::SUPPLY_BIT] <= 1'b1;
         end
         if (lockErr) begin
            status_reg[flash_qe_pkg::LOCKED_ERR_BIT] <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Read path.
   // -------------------------------------------------------------------------
   // Table bytes keep their voltage coding: upper nibble volts, lower nibble
   // tenths in decimal, e.g. 33h is 3.3 V.
   wire [7:0] extByte = (extIdx == 8'(flash_qe_pkg::SUSP_CAP_IDX) && !x32)
                        ? flash_qe_pkg::SUSP_CAP_X16
                        : flash_qe_pkg::EXT_TABLE[extIdx[3:0]];
   // Block status byte: only the lock flag, the rest reserved zero.
   wire [7:0] bsrByte = {7'h00, lb.rdLock};
   wire [7:0] qByte   = isBsr ? bsrByte : (isExt ? extByte : 8'h00);
   // Array data are not modelled here; they read as erased.
   wire [31:0] rdWord = (rdMode_reg == flash_qe_pkg::RD_STATUS) ? {24'h000000, status_reg} :
                        (rdMode_reg == flash_qe_pkg::RD_QUERY)  ? {24'h000000, qByte} :
                        32'hFFFFFFFF;

   // Outputs are registered; drive only with chip and output enabled.
   always_ff @(posedge clk) begin
      if (srst) begin
         dataOut    <= '0;
         dataOe_n   <= 1'b1;
         readyBusy  <= 1'b1;
         eraseStart <= 1'b0;
         eraseBlock <= '0;
      end else begin
         dataOut    <= rdWord;
         dataOe_n   <= ceN | oeN | ~weN;
         readyBusy  <= status_reg[flash_qe_pkg::READY_BIT];
         eraseStart <= (state_reg == flash_qe_pkg::ST_IDLE) && (state_next == flash_qe_pkg::ST_ERASING);
         if (state_reg == flash_qe_pkg::ST_IDLE && state_next == flash_qe_pkg::ST_ERASING) begin
            eraseBlock <= tgtBlock_reg;  // Locked blocks never reach here.
         end
      end
   end

   // -------------------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------------------
   chk_status_upper_zero: assert property (@(posedge clk) disable iff (srst)
      (rdMode_reg == flash_qe_pkg::RD_QUERY && isBsr) |=> dataOut[31:1] == '0)
      else $error("block status reserved bits not zero");
   chk_query_low_lines: assert property (@(posedge clk) disable iff (srst)
      (rdMode_reg == flash_qe_pkg::RD_QUERY) |=> dataOut[31:8] == '0)
      else $error("query data above low byte");
   chk_lock_bit_read: assert property (@(posedge clk) disable iff (srst)
      (rdMode_reg == flash_qe_pkg::RD_QUERY && isBsr && $stable(addrBlock))
      |=> dataOut[0] == $past(u_locks.lock_reg[addrBlock], 2))
      else $error("block status lock bit wrong");
   chk_erase_to_status: assert property (@(posedge clk) disable iff (srst)
      isConfirm |=> rdMode_reg == flash_qe_pkg::RD_STATUS)
      else $error("erase did not select status reads");
   chk_seq_error_pair: assert property (@(posedge clk) disable iff (srst)
      badSeq |=> status_reg[5:4] == 2'b11)
      else $error("sequence error bits not set");
   chk_locked_no_erase: assert property (@(posedge clk) disable iff (srst)
      lockErr |=> status_reg[1] && !eraseStart && state_reg == flash_qe_pkg::ST_IDLE)
      else $error("locked block erase misreported");
   chk_supply_error: assert property (@(posedge clk) disable iff (srst)
      vppErr |=> status_reg[3] && state_reg != flash_qe_pkg::ST_ERASING)
      else $error("supply error misreported");
   chk_erase_fail_alone: assert property (@(posedge clk) disable iff (srst)
      (failErr && !badSeq && !status_reg[4]) |=> status_reg[5] && !status_reg[4])
      else $error("erase failure bits wrong");
   chk_ready_busy: assert property (@(posedge clk) disable iff (srst)
      (state_reg == flash_qe_pkg::ST_ERASING) |-> !status_reg[7])
      else $error("ready shown during erase");
   chk_errors_sticky: assert property (@(posedge clk) disable iff (srst)
      ($fell(status_reg[5]) || $fell(status_reg[3])) |-> $past(clrStat))
      else $error("error bit lost without clear");
   chk_ext_signature: assert property (@(posedge clk) disable iff (srst)
      (rdMode_reg == flash_qe_pkg::RD_QUERY && !isBsr && qSel == flash_qe_pkg::EXT_FIRST)
      |=> dataOut[7:0] == 8'h50)
      else $error("extended table signature wrong");
endmodule : flash_query_and_erase_flow
`default_nettype wire

// ### test/flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------
// Host controller model driving the flash pins.
// -------------------------------------------------------------
module flash_host_model (
   input  wire logic        clk,        // System clock.
   input  wire logic [31:0] dataOut,    // Read data from the device.
   output logic      [20:0] addrLines,  // Word address A21..A1.
   output logic      [31:0] dataIn,     // Write data lines.
   output logic             chipEn_n,   // Chip enable.
   output logic             outEn_n,    // Output enable.
   output logic             writeEn_n   // Write enable.
);
   // Idle bus at time zero.
   initial begin
      addrLines = 21'h000000;
      dataIn    = 32'h00000000;
      chipEn_n  = 1'b1;
      outEn_n   = 1'b1;
      writeEn_n = 1'b1;
   end
   // Pins stay put four clocks around the strobe rise, longer than the synchroniser needs.
   task automatic busWrite(input logic [20:0] a, input logic [7:0] d);
      @(negedge clk);
      addrLines = a;
      dataIn    = {24'h000000, d};
      chipEn_n  = 1'b0;
      writeEn_n = 1'b0;
      repeat (4) @(negedge clk);
      writeEn_n = 1'b1;
      repeat (4) @(negedge clk);
      chipEn_n  = 1'b1;
      dataIn    = ~dataIn;  // Released lines must not keep showing the command.
   endtask : busWrite
   // Read waits six clocks, past the three or four the device needs.
   task automatic busRead(input logic [20:0] a, output logic [31:0] d);
      @(negedge clk);
      addrLines = a;
      chipEn_n  = 1'b0;
      outEn_n   = 1'b0;
      repeat (6) @(negedge clk);
      d         = dataOut;
      outEn_n   = 1'b1;
      chipEn_n  = 1'b1;
   endtask : busRead
endmodule : flash_host_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------
// Self-checking bench for the query and erase block.
// -------------------------------------------------------------
module tb;
   logic        clk = 1'b0;                  // 40 MHz clock.
   logic        srst = 1'b1;                 // Reset, held at start.
   logic        wordMode = 1'b1;             // Bus width select.
   logic        supplyOk = 1'b1;             // Program supply level.
   logic        eraseFault = 1'b0;           // Array erase result.
   wire  [20:0] addrLines;                   // Host address.
   wire  [31:0] dataIn, dataOut;             // Data halves.
   wire         chipEn_n, outEn_n, writeEn_n, dataOe_n, readyBusy, eraseStart;
   wire  [4:0]  eraseBlock;                  // Erase target.
   int          errorCnt = 0, checksDone = 0, starts = 0;
   logic [4:0]  lastBlk;                     // Block seen at the last start pulse.
   // Extended table written out by hand, 32-bit column.
   localparam logic [7:0] QT [15] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h31, 8'h0E, 8'h00,
      8'h00, 8'h00, 8'h01, 8'h00, 8'h33, 8'h50, 8'h00, 8'h00};
   always #12.5 clk = ~clk;
   // Count start pulses at the falling edge, where the registered pulse has
   // settled; it lasts one cycle, so each pulse is seen exactly once.
   always @(negedge clk) begin
      if (eraseStart === 1'b1) begin
         starts++;
         lastBlk = eraseBlock;
      end
   end
   flash_query_and_erase_flow #(.ERASE_CYCLES(20)) dut_u (.clk(clk), .srst(srst),
      .addrLines(addrLines), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
      .chipEn_n(chipEn_n), .outEn_n(outEn_n), .writeEn_n(writeEn_n), .wordMode(wordMode),
      .supplyOk(supplyOk), .eraseFault(eraseFault), .readyBusy(readyBusy),
      .eraseStart(eraseStart), .eraseBlock(eraseBlock));
   flash_host_model host_u (.clk(clk), .dataOut(dataOut), .addrLines(addrLines),
      .dataIn(dataIn), .chipEn_n(chipEn_n), .outEn_n(outEn_n), .writeEn_n(writeEn_n));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic summarize;
      if (errorCnt == 0 && checksDone > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   // Lock block 5, then read the status bytes of block 5 and block 4 and the whole table.
   task automatic queryX32;
      logic [31:0] d;
      host_u.busWrite({5'd5, 16'h0000}, 8'h60);
      host_u.busWrite({5'd5, 16'h0000}, 8'h01);
      host_u.busWrite(21'h000000, 8'h98);
      check({31'h0, dataOe_n}, 32'h1);
      host_u.busRead({5'd5, 16'h0004}, d);
      check(d, 32'h00000001);
      check({31'h0, dataOe_n}, 32'h0);
      host_u.busRead({5'd4, 16'h0004}, d);
      check(d, 32'h00000000);
      for (int i = 0; i < 15; i++) begin
         host_u.busRead(21'((8'h31 + i) << 1), d);
         check(d, {24'h000000, QT[i]});
      end
   endtask : queryX32
   // Narrow width: each entry answers at two word addresses in a row.
   task automatic queryX16;
      logic [31:0] d;
      @(negedge clk);
      wordMode = 1'b0;
      for (int i = 0; i < 30; i++) begin
         host_u.busRead(21'(8'h62 + i), d);
         check(d, {24'h000000, (i / 2 == 9) ? 8'h00 : QT[i / 2]});
      end
      @(negedge clk);
      wordMode = 1'b1;
   endtask : queryX16
   // Setup, second code, poll to ready, then clear; a refused erase never starts.
   task automatic eraseRun(input logic [4:0] blk, input logic sup, input logic flt,
                           input logic [7:0] second, input logic [7:0] expSt, input int go);
      logic [31:0] d;
      int          n0;
      n0 = starts;
      @(negedge clk);
      supplyOk   = sup;
      eraseFault = flt;
      host_u.busWrite({blk, 16'h0000}, 8'h20);
      host_u.busWrite({blk, 16'h0123}, second);
      host_u.busRead({blk, 16'h0000}, d);
      check({31'h0, d[7]}, {31'h0, go == 0});
      check({31'h0, readyBusy}, {31'h0, go == 0});
      for (int i = 0; i < 20 && d[7] !== 1'b1; i++) begin
         host_u.busRead({blk, 16'h0000}, d);
      end
      check(d, {24'h000000, expSt});
      check(starts - n0, go);
      if (go == 1) check({27'h0, lastBlk}, {27'h0, blk});
      host_u.busRead({blk, 16'h0000}, d);
      check(d, {24'h000000, expSt});
      host_u.busWrite(21'h000000, 8'h50);
      host_u.busRead(21'h000000, d);
      check(d, 32'h00000080);
      check({31'h0, readyBusy}, 32'h1);
   endtask : eraseRun
   // Suspend a busy erase, then resume it to the end.
   task automatic suspendRun;
      logic [31:0] d;
      host_u.busWrite(21'h020000, 8'h20);
      host_u.busWrite(21'h020000, 8'hD0);
      host_u.busWrite(21'h020000, 8'hB0);
      host_u.busRead(21'h020000, d);
      check({31'h0, d[6]}, 32'h1);
      host_u.busWrite(21'h020000, 8'hD0);
      repeat (60) @(negedge clk);
      host_u.busRead(21'h020000, d);
      check(d, 32'h00000080);
      host_u.busWrite(21'h000000, 8'hFF);
      host_u.busRead(21'h000000, d);
      check(d, 32'hFFFFFFFF);
   endtask : suspendRun
   initial begin
      repeat (3) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      queryX32();
      queryX16();
      eraseRun(5'd2, 1'b1, 1'b0, 8'hD0, 8'h80, 1);
      eraseRun(5'd2, 1'b1, 1'b1, 8'hD0, 8'hA0, 1);
      eraseRun(5'd5, 1'b1, 1'b0, 8'hD0, 8'h82, 0);
      eraseRun(5'd2, 1'b0, 1'b0, 8'hD0, 8'h88, 0);
      eraseRun(5'd2, 1'b1, 1'b0, 8'h70, 8'hB0, 0);
      suspendRun();
      summarize();
   end
endmodule : tb
`default_nettype wire
